/* File: hw/pdc_reg_cache.sv */
// Purpose: Register bank, calibration engine and cached-code DAC loading for four channels
// Assumes: APB slave with zero wait states; pins sampled through three flip-flops
// Notes on behaviour
// - DAC readback returns a 24-bit word
// - Top two bits give register type
// - Bits 21..16 hold DAC register address
// - Bits 15..0 hold register contents
// - Gains reset full scale, offsets midscale
// - Alarm and comparator status reset presets
// - Input codes reset to listed defaults
// - System word resets zero except bit5
// - PMU word resets range, measure, flags high
// - All channels start in known state
// - Input code write triggers calibration and caching
// - PMU write applies switches, loads cached codes
// - Non-selected mode codes cached, not driven
// - Separate codes per voltage/current range
// - Force select hi-Z opens force switch
// - Hi-Z mode loads force/clamp codes directly
// - Writing PMU bit6 clears latched overtemp
//
// The APB slave port and the register offsets were left to the implementer.
`default_nettype none
`timescale 1ns/1ps
module pdc_reg_cache #(
  parameter pdc_pkg::pdc_decode_t DAC_DECODE = pdc_pkg::pdc_decode_default()
) (
  // Clock and reset
  input  wire logic                                     clock,
  input  wire logic                                     srst,
  // APB slave
  input  wire logic                                     psel,
  input  wire logic                                     penable,
  input  wire logic                                     pwrite,
  input  wire logic [11:0]                              paddr,
  input  wire logic [31:0]                              pwdata,
  output var  logic [31:0]                              prdata_q,
  output var  logic                                     pready_q,
  output var  logic                                     pslverr_q,
  // Asynchronous pins
  input  wire logic                                     overtemp_pin,
  input  wire logic [7:0]                               cmp_pin,
  // DAC and switch outputs
  output var  pdc_pkg::pdc_dac_out_t [pdc_pkg::NCH-1:0] dac_out_q,
  output var  logic [15:0]                              offset_dac_q,
  output var  logic [pdc_pkg::NCH-1:0]                  force_sw_q,
  output var  logic [pdc_pkg::NCH-1:0][21:0]            pmu_q,
  output var  logic [21:0]                              sysctl_q
);
  import pdc_pkg::*;

  logic [15:0]    gain_q [NCH][NDAC];
  logic [15:0]    offs_q [NCH][NDAC];
  logic [15:0]    x1_q   [NCH][NDAC];
  logic [15:0]    x2_q   [NCH][NDAC];
  logic [25:0]    rdsel_q;
  logic [8:0]     s1_q;
  logic [8:0]     s2_q;
  logic [8:0]     s3_q;
  logic [8:0]     filt_q;
  logic           lt_n_q;
  logic           t_n_q;
  pdc_cal_state_t cal_state_q;
  logic [1:0]     cal_ch_q;
  logic [4:0]     cal_idx_q;
  logic           setup;
  logic           acc;
  logic           wr_acc;
  logic           dac_wr;
  logic           wr_pmu;
  logic [1:0]     wr_ch;
  logic [1:0]     dw_ch;
  logic [4:0]     dw_idx;
  logic           dacwr_bad;
  logic [4:0]     pmu_fin_idx;
  logic [4:0]     rb_idx;
  logic [15:0]    rb_data;
  logic [23:0]    rb_word;
  logic [23:0]    alarm_word;
  logic [23:0]    comp_word;
  logic [31:0]    rd_data;
  logic           addr_err;
  logic [32:0]    cal_prod;
  logic [18:0]    cal_sum;
  logic [15:0]    cal_x2;
  logic [4:0]     cal_fin_idx;
  logic           cal_hiz;
  logic           cal_hit;

  // Bus phase decode
  assign setup  = psel & ~penable;
  assign acc    = psel & penable & pready_q;
  assign wr_acc = acc & pwrite & ~pslverr_q;
  assign dac_wr = wr_acc & (paddr == ADDR_DACWR);
  assign wr_pmu = wr_acc & (paddr[11:4] == ADDR_PMU0[11:4]);
  assign wr_ch  = paddr[3:2];

  // DAC write word fields and table lookup
  assign dw_ch       = pwdata[DW_CH_LO+1:DW_CH_LO];
  assign dw_idx      = DAC_DECODE[pwdata[21:16]];
  assign dacwr_bad   = (pwdata[23:22] == 2'h0) | (dw_idx >= 5'(NDAC));
  assign pmu_fin_idx = IDX_FIN + {2'h0, pdc_slot(pwdata[21:0])};

  // Readback word assembly
  assign rb_idx  = DAC_DECODE[rdsel_q[21:16]];
  always_comb begin
    rb_data = 16'h0000;
    if (rb_idx < 5'(NDAC)) begin
      case (rdsel_q[23:22])
        RBT_GAIN: rb_data = gain_q[rdsel_q[25:24]][rb_idx];
        RBT_OFFS: rb_data = offs_q[rdsel_q[25:24]][rb_idx];
        RBT_X1:   rb_data = x1_q[rdsel_q[25:24]][rb_idx];
        default:  rb_data = 16'h0000;
      endcase
    end
  end
  assign rb_word    = {rdsel_q[23:22], rdsel_q[21:16], rb_data};
  assign alarm_word = {ALARM_RST[23:22], lt_n_q, t_n_q, ALARM_RST[19:0]};
  assign comp_word  = COMP_RST | {2'h0, filt_q[7:0], 14'h0000};

  // Register read mux and address check
  always_comb begin
    rd_data  = 32'h0000_0000;
    addr_err = 1'b0;
    case (paddr)
      ADDR_SYSCTL: rd_data = {10'h000, sysctl_q};
      ADDR_PMU0, ADDR_PMU0 + 12'h004, ADDR_PMU0 + 12'h008, ADDR_PMU0 + 12'h00C: begin
        rd_data = {10'h000, pmu_q[wr_ch][21:7], lt_n_q, t_n_q, pmu_q[wr_ch][4:0]};
      end
      ADDR_ALARM: begin
        rd_data  = {8'h00, alarm_word};
        addr_err = pwrite;
      end
      ADDR_CMPST: begin
        rd_data  = {8'h00, comp_word};
        addr_err = pwrite;
      end
      ADDR_DACWR: addr_err = pwrite & dacwr_bad;
      ADDR_RDSEL: rd_data = {6'h00, rdsel_q};
      ADDR_RDBACK: begin
        rd_data  = {8'h00, rb_word};
        addr_err = pwrite;
      end
      default: addr_err = 1'b1;
    endcase
  end

  // APB answer: ready in first access cycle, data and error captured in setup
  always_ff @(posedge clock) begin
    if (srst) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q <= setup;
      if (setup) begin
        pslverr_q <= addr_err;
        prdata_q  <= pwrite ? 32'h0000_0000 : rd_data;
      end
    end
  end

  // System word, PMU words and readback select
  always_ff @(posedge clock) begin
    if (srst) begin
      sysctl_q <= SYSCTL_RST;
      rdsel_q  <= 26'h000_0000;
      for (int c = 0; c < NCH; c++) begin
        pmu_q[c] <= PMU_RST;
      end
    end else if (wr_acc) begin
      if (paddr == ADDR_SYSCTL) sysctl_q <= pwdata[21:0];
      if (paddr == ADDR_RDSEL) rdsel_q <= pwdata[25:0];
      if (wr_pmu) pmu_q[wr_ch] <= pwdata[21:0];
    end
  end

  // Three-stage pin sampling, change taken when stages two and three agree
  always_ff @(posedge clock) begin
    if (srst) begin
      s1_q   <= 9'h000;
      s2_q   <= 9'h000;
      s3_q   <= 9'h000;
      filt_q <= 9'h000;
    end else begin
      s1_q   <= {overtemp_pin, cmp_pin};
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      filt_q <= (s2_q & s3_q) | (filt_q & (s2_q | s3_q));
    end
  end

  // Temperature flags, active low; a new event beats the clear
  always_ff @(posedge clock) begin
    if (srst) begin
      lt_n_q <= 1'b1;
      t_n_q  <= 1'b1;
    end else begin
      t_n_q <= ~filt_q[8];
      if (filt_q[8]) begin
        lt_n_q <= 1'b0;
      end else if (wr_pmu && pwdata[PMU_LT_BIT]) begin
        lt_n_q <= 1'b1;
      end
    end
  end

  // Force switch: closed only when channel on, not hi-Z, no thermal shutdown
  always_ff @(posedge clock) begin
    if (srst) begin
      force_sw_q <= '0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        force_sw_q[c] <= pmu_q[c][PMU_CH_ON] & ~pmu_q[c][PMU_FSEL_HI]
                         & ~(sysctl_q[SYS_OT_SHDN] & filt_q[8]);
      end
    end
  end

  // Calibration arithmetic on the pending register
  assign cal_prod = x1_q[cal_ch_q][cal_idx_q] * {1'b0, gain_q[cal_ch_q][cal_idx_q]}
                    + {17'h0_0000, x1_q[cal_ch_q][cal_idx_q]};
  assign cal_sum  = {2'h0, cal_prod[32:16]} + {3'h0, offs_q[cal_ch_q][cal_idx_q]} - CAL_MID;
  assign cal_x2   = cal_sum[18] ? 16'h0000 : (cal_sum[17:16] != 2'h0) ? 16'hFFFF
                    : cal_sum[15:0];

  // Calibration sequencer: one cycle after an input code write
  always_ff @(posedge clock) begin
    if (srst) begin
      cal_state_q <= CAL_IDLE;
      cal_ch_q    <= 2'h0;
      cal_idx_q   <= 5'h00;
    end else begin
      case (cal_state_q)
        CAL_IDLE: begin
          if (dac_wr && pwdata[23:22] == RBT_X1) begin
            cal_state_q <= CAL_RUN;
            cal_ch_q    <= dw_ch;
            cal_idx_q   <= dw_idx;
          end
        end
        CAL_RUN: cal_state_q <= CAL_IDLE;
        default: cal_state_q <= CAL_IDLE;
      endcase
    end
  end

  // Coefficient, input code and cached code storage
  always_ff @(posedge clock) begin
    if (srst) begin
      for (int c = 0; c < NCH; c++) begin
        for (int d = 0; d < NDAC; d++) begin
          gain_q[c][d] <= GAIN_RST;
          offs_q[c][d] <= OFFS_RST;
          x1_q[c][d]   <= pdc_x1_rst(d);
          x2_q[c][d]   <= pdc_x1_rst(d);
        end
      end
    end else begin
      if (dac_wr) begin
        case (pwdata[23:22])
          RBT_GAIN: gain_q[dw_ch][dw_idx] <= pwdata[15:0];
          RBT_OFFS: offs_q[dw_ch][dw_idx] <= pwdata[15:0];
          RBT_X1:   x1_q[dw_ch][dw_idx] <= pwdata[15:0];
          default:  ;
        endcase
      end
      if (cal_state_q == CAL_RUN) begin
        x2_q[cal_ch_q][cal_idx_q] <= cal_x2;
      end
    end
  end

  // Direct load decision while in hi-Z
  assign cal_fin_idx = IDX_FIN + {2'h0, pdc_slot(pmu_q[cal_ch_q])};
  assign cal_hiz     = pmu_q[cal_ch_q][PMU_FSEL_HI];
  assign cal_hit     = (cal_state_q == CAL_RUN) & cal_hiz
                       & ((cal_idx_q == cal_fin_idx) | (cal_idx_q == IDX_CLL)
                       | (cal_idx_q == IDX_CLH));

  // DAC loading from cached codes
  always_ff @(posedge clock) begin
    if (srst) begin
      offset_dac_q <= OFFDAC_RST;
      for (int c = 0; c < NCH; c++) begin
        dac_out_q[c] <= '{FIN_RST, CLL_RST, CLH_RST, CPL_RST, CPH_RST};
      end
    end else if (wr_pmu) begin
      dac_out_q[wr_ch].force_lvl <= x2_q[wr_ch][pmu_fin_idx];
      dac_out_q[wr_ch].cmp_lo    <= x2_q[wr_ch][pmu_fin_idx + IDX_CPL];
      dac_out_q[wr_ch].cmp_hi    <= x2_q[wr_ch][pmu_fin_idx + IDX_CPH];
      dac_out_q[wr_ch].clamp_lo  <= x2_q[wr_ch][IDX_CLL];
      dac_out_q[wr_ch].clamp_hi  <= x2_q[wr_ch][IDX_CLH];
    end else if (cal_state_q == CAL_RUN) begin
      if (cal_idx_q == IDX_OFF) offset_dac_q <= cal_x2;
      if (cal_hit && cal_idx_q == cal_fin_idx) begin
        dac_out_q[cal_ch_q].force_lvl <= cal_x2;
      end
      if (cal_hit && cal_idx_q == IDX_CLL) dac_out_q[cal_ch_q].clamp_lo <= cal_x2;
      if (cal_hit && cal_idx_q == IDX_CLH) dac_out_q[cal_ch_q].clamp_hi <= cal_x2;
    end
  end

  // Checks
  sequence s_rb_read;
    setup && !pwrite && paddr == ADDR_RDBACK;
  endsequence
  sequence s_x1_write;
    dac_wr && pwdata[23:22] == RBT_X1;
  endsequence

  property p_rb_width;
    @(posedge clock) disable iff (srst) s_rb_read |=> prdata_q[31:24] == 8'h00;
  endproperty
  a_rb_width: assert property (p_rb_width) else $error("readback wider than 24 bits");

  property p_rb_type;
    @(posedge clock) disable iff (srst) s_rb_read |=> prdata_q[23:22] == $past(rdsel_q[23:22]);
  endproperty
  a_rb_type: assert property (p_rb_type) else $error("readback type field wrong");

  property p_rb_addr;
    @(posedge clock) disable iff (srst) s_rb_read |=> prdata_q[21:16] == $past(rdsel_q[21:16]);
  endproperty
  a_rb_addr: assert property (p_rb_addr) else $error("readback address field wrong");

  property p_rb_data;
    @(posedge clock) disable iff (srst)
      s_rb_read and (rdsel_q[23:22] == RBT_X1 && rb_idx == IDX_CLL)
      |=> prdata_q[15:0] == $past(x1_q[rdsel_q[25:24]][IDX_CLL]);
  endproperty
  a_rb_data: assert property (p_rb_data) else $error("readback data field wrong");

  property p_rst_coeff;
    @(posedge clock) $fell(srst) |-> gain_q[3][20] == GAIN_RST && offs_q[1][5] == OFFS_RST;
  endproperty
  a_rst_coeff: assert property (p_rst_coeff) else $error("coefficient reset wrong");

  property p_rst_status;
    @(posedge clock) $fell(srst) |-> alarm_word == ALARM_RST && comp_word == COMP_RST;
  endproperty
  a_rst_status: assert property (p_rst_status) else $error("status reset wrong");

  property p_rst_codes;
    @(posedge clock) $fell(srst) |-> x1_q[0][IDX_OFF] == OFFDAC_RST && x1_q[2][IDX_CLH] == CLH_RST
      && dac_out_q[1].force_lvl == FIN_RST && offset_dac_q == OFFDAC_RST;
  endproperty
  a_rst_codes: assert property (p_rst_codes) else $error("input code reset wrong");

  property p_rst_words;
    @(posedge clock) $fell(srst) |-> sysctl_q == SYSCTL_RST && pmu_q[3] == PMU_RST;
  endproperty
  a_rst_words: assert property (p_rst_words) else $error("control word reset wrong");

  property p_cal_seq;
    @(posedge clock) disable iff (srst)
      s_x1_write |=> (cal_state_q == CAL_RUN && cal_idx_q == $past(dw_idx)) ##1
      cal_state_q == CAL_IDLE;
  endproperty
  a_cal_seq: assert property (p_cal_seq) else $error("calibration not started");

  property p_pmu_load;
    @(posedge clock) disable iff (srst)
      wr_pmu |=> dac_out_q[$past(wr_ch)].force_lvl == x2_q[$past(wr_ch)][$past(pmu_fin_idx)];
  endproperty
  a_pmu_load: assert property (p_pmu_load) else $error("PMU write did not load code");

  property p_no_drive;
    @(posedge clock) disable iff (srst)
      cal_state_q == CAL_RUN && !cal_hit && cal_idx_q != IDX_OFF |=> $stable(dac_out_q);
  endproperty
  a_no_drive: assert property (p_no_drive) else $error("unselected code reached DAC");

  property p_range_sep;
    @(posedge clock) disable iff (srst)
      s_x1_write and (dw_ch == 2'h0 && dw_idx == IDX_FIN) |=> $stable(x1_q[0][1]);
  endproperty
  a_range_sep: assert property (p_range_sep) else $error("range codes not separate");

  property p_hiz_sw;
    @(posedge clock) disable iff (srst) pmu_q[0][PMU_FSEL_HI] |=> !force_sw_q[0];
  endproperty
  a_hiz_sw: assert property (p_hiz_sw) else $error("force switch closed in hi-Z");

  property p_hiz_load;
    @(posedge clock) disable iff (srst)
      cal_state_q == CAL_RUN && cal_hiz && cal_idx_q == IDX_CLL
      |=> dac_out_q[$past(cal_ch_q)].clamp_lo == $past(cal_x2);
  endproperty
  a_hiz_load: assert property (p_hiz_load) else $error("hi-Z clamp not loaded");

  property p_ot_clear;
    @(posedge clock) disable iff (srst)
      wr_pmu && pwdata[PMU_LT_BIT] && !filt_q[8] |=> lt_n_q;
  endproperty
  a_ot_clear: assert property (p_ot_clear) else $error("latched overtemp not cleared");

  property p_ot_set;
    @(posedge clock) disable iff (srst) filt_q[8] |=> !lt_n_q && !t_n_q;
  endproperty
  a_ot_set: assert property (p_ot_set) else $error("overtemp event lost");

  property p_decode;
    @(posedge clock) disable iff (srst)
      dac_wr && pwdata[23:22] == RBT_GAIN
      |=> gain_q[$past(dw_ch)][$past(dw_idx)] == $past(pwdata[15:0]);
  endproperty
  a_decode: assert property (p_decode) else $error("decoded gain write wrong");
endmodule
`default_nettype wire

/* File: hw/pdc_pkg.sv */
// Purpose: Shared constants, types and helpers for the calibrated DAC register cache
// Assumes: Four channels, 16-bit DAC codes, APB byte addresses on 12 bits
// Notes:   Calibration is x2 = x1 * (gain + 1) / 2^16 + offset - 2^15, saturated
`default_nettype none
package pdc_pkg;
  // Sizes
  localparam int NCH  = 4;
  localparam int NDAC = 21;
  // APB register map
  localparam logic [11:0] ADDR_SYSCTL = 12'h000;
  localparam logic [11:0] ADDR_PMU0   = 12'h010;
  localparam logic [11:0] ADDR_ALARM  = 12'h020;
  localparam logic [11:0] ADDR_CMPST  = 12'h024;
  localparam logic [11:0] ADDR_DACWR  = 12'h030;
  localparam logic [11:0] ADDR_RDSEL  = 12'h034;
  localparam logic [11:0] ADDR_RDBACK = 12'h038;
  // Reset values
  localparam logic [15:0] GAIN_RST    = 16'hFFFF;
  localparam logic [15:0] OFFS_RST    = 16'h8000;
  localparam logic [15:0] OFFDAC_RST  = 16'hA492;
  localparam logic [15:0] FIN_RST     = 16'h8000;
  localparam logic [15:0] CLL_RST     = 16'h0000;
  localparam logic [15:0] CLH_RST     = 16'hFFFF;
  localparam logic [15:0] CPL_RST     = 16'h0000;
  localparam logic [15:0] CPH_RST     = 16'hFFFF;
  localparam logic [23:0] ALARM_RST   = 24'hFF_FFF0;
  localparam logic [23:0] COMP_RST    = 24'h40_0000;
  localparam logic [21:0] SYSCTL_RST  = 22'h00_0020;
  localparam logic [21:0] PMU_RST     = 22'h01_E060;
  localparam logic [18:0] CAL_MID     = 19'h0_8000;
  // Field positions
  localparam int PMU_CH_ON   = 21;
  localparam int PMU_FSEL_HI = 20;
  localparam int PMU_FSEL_LO = 19;
  localparam int PMU_RNG_HI  = 17;
  localparam int PMU_RNG_LO  = 15;
  localparam int PMU_LT_BIT  = 6;
  localparam int SYS_OT_SHDN = 5;
  localparam int DW_CH_LO    = 24;
  // Readback register type codes
  localparam logic [1:0] RBT_GAIN = 2'h1;
  localparam logic [1:0] RBT_OFFS = 2'h2;
  localparam logic [1:0] RBT_X1   = 2'h3;
  // DAC register indices within a channel
  localparam logic [4:0] IDX_FIN  = 5'h00;
  localparam logic [4:0] IDX_CPL  = 5'h06;
  localparam logic [4:0] IDX_CPH  = 5'h0C;
  localparam logic [4:0] IDX_CLL  = 5'h12;
  localparam logic [4:0] IDX_CLH  = 5'h13;
  localparam logic [4:0] IDX_OFF  = 5'h14;
  localparam logic [4:0] IDX_NONE = 5'h1F;

  typedef struct packed {
    logic [15:0] force_lvl;
    logic [15:0] clamp_lo;
    logic [15:0] clamp_hi;
    logic [15:0] cmp_lo;
    logic [15:0] cmp_hi;
  } pdc_dac_out_t;

  typedef logic [63:0][4:0] pdc_decode_t;

  typedef enum logic [1:0] {
    CAL_IDLE = 2'b01,
    CAL_RUN  = 2'b10
  } pdc_cal_state_t;

  // Identity table for the first indices, rest unmapped
  function automatic pdc_decode_t pdc_decode_default();
    pdc_decode_t t;
    for (int i = 0; i < 64; i++) begin
      t[i] = (i < NDAC) ? 5'(i) : IDX_NONE;
    end
    return t;
  endfunction

  // Range slot: 0 for voltage, 1..5 for current ranges
  function automatic logic [2:0] pdc_slot(logic [21:0] w);
    if (!w[PMU_FSEL_LO]) begin
      return 3'h0;
    end
    if (w[PMU_RNG_HI:PMU_RNG_LO] > 3'h4) begin
      return 3'h5;
    end
    return w[PMU_RNG_HI:PMU_RNG_LO] + 3'h1;
  endfunction

  // Power-on input code for a register index
  function automatic logic [15:0] pdc_x1_rst(int i);
    if (i < 6) return FIN_RST;
    if (i < 12) return CPL_RST;
    if (i < 18) return CPH_RST;
    if (i == 18) return CLL_RST;
    if (i == 19) return CLH_RST;
    return OFFDAC_RST;
  endfunction
endpackage
`default_nettype wire

/* File: tb/pdc_apb_host.sv */
// Purpose: Host controller model that drives the register bus of the cache
// Assumes: Zero or more wait states, answer seen as pready_q high at a rising edge
// Notes:   Bus signals idle at time zero, then change only by non-blocking assignment just after a rising edge
`default_nettype none
`timescale 1ns/1ps
module pdc_apb_host (
  // Clock
  input  wire logic        clock,
  // Bus request side
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  // Bus answer side
  input  wire logic [31:0] prdata_q,
  input  wire logic        pready_q,
  input  wire logic        pslverr_q
);
  logic hung;

  // Idle bus from time zero
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
    hung    = 1'b0;
  end

  // One transfer: setup, access held until pready, then release
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready_q !== 1'b1 && n < 40);
    hung    = (n >= 40);
    r       = prdata_q;
    e       = pslverr_q;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: tb/pmu_dac_calibrated_register_cache_test.sv */
// Purpose: Self-checking bench for the calibrated DAC register cache
// Assumes: Default identity decode table, 50 MHz clock
// Notes:   Calibration expectations come from the bench's own arithmetic
`default_nettype none
`timescale 1ns/1ps
module pmu_dac_calibrated_register_cache_test;
  import pdc_pkg::*;
  logic                       clock = 1'b0;
  logic                       srst = 1'b1;
  logic                       psel, penable, pwrite, pready_q, pslverr_q, serr;
  logic [11:0]                paddr;
  logic [31:0]                pwdata, prdata_q, rdat;
  logic                       overtemp_pin = 1'b0;
  logic [7:0]                 cmp_pin = 8'h00;
  pdc_dac_out_t [NCH-1:0]     dac_out_q;
  logic [15:0]                offset_dac_q, g, o, x, xb;
  logic [NCH-1:0]             force_sw_q;
  logic [NCH-1:0][21:0]       pmu_q;
  logic [21:0]                sysctl_q;
  int                         fail_count = 0;
  int                         samples_checked = 0;
  int                         seed = 54068;
  logic [23:0]                rb_tab [8] = '{24'h40_FFFF, 24'h85_8000, 24'hC0_8000, 24'hC6_0000,
                                             24'hCC_FFFF, 24'hD2_0000, 24'hD3_FFFF, 24'hD4_A492};

  // Clock at 20 ns
  always #10 clock = ~clock;

  pdc_reg_cache u_dut (.clock(clock), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q),
    .pready_q(pready_q), .pslverr_q(pslverr_q), .overtemp_pin(overtemp_pin),
    .cmp_pin(cmp_pin), .dac_out_q(dac_out_q), .offset_dac_q(offset_dac_q),
    .force_sw_q(force_sw_q), .pmu_q(pmu_q), .sysctl_q(sysctl_q));

  pdc_apb_host u_host (.clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q),
    .pslverr_q(pslverr_q));

  // Saturated calibration of an input code
  function automatic logic [15:0] cal(logic [15:0] xi, logic [15:0] gi, logic [15:0] oi);
    longint v;
    v = ((longint'(xi) * (longint'(gi) + 1)) >>> 16) + longint'(oi) - 32768;
    if (v < 0) v = 0;
    if (v > 65535) v = 65535;
    return v[15:0];
  endfunction

  // DAC write word: channel, type, address, data
  function automatic logic [31:0] dw(int ch, logic [1:0] t, logic [5:0] a, logic [15:0] v);
    return {6'h00, 2'(ch), t, a, v};
  endfunction

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [79:0] exp, input logic [79:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Bus access with its error flag compared
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d, input logic e);
    u_host.xfer(w, a, d, rdat, serr);
    if (u_host.hung) begin
      fail_count++;
      $display("[FAIL] pready expected 1 seen 0");
      report_and_stop();
    end
    chk("pslverr", 80'(e), 80'(serr));
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // Main sequence
  initial begin
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    tick(1);
    chk("dac ch0", 80'h8000_0000_FFFF_0000_FFFF, dac_out_q[0]);
    chk("offset dac", 80'hA492, 80'(offset_dac_q));
    chk("sysctl", 80'h20, 80'(sysctl_q));
    acc(1'b1, ADDR_SYSCTL, 32'h0000_0020, 1'b0);
    acc(1'b0, ADDR_PMU0, 32'h0, 1'b0);
    chk("pmu0", 80'h01_E060, 80'(rdat));
    acc(1'b0, ADDR_ALARM, 32'h0, 1'b0);
    chk("alarm", 80'hFF_FFF0, 80'(rdat));
    acc(1'b0, ADDR_CMPST, 32'h0, 1'b0);
    chk("cmp status", 80'h40_0000, 80'(rdat));
    @(posedge clock);
    cmp_pin <= 8'($random(seed));
    tick(5);
    acc(1'b0, ADDR_CMPST, 32'h0, 1'b0);
    chk("cmp pins", 80'(32'h40_0000 | (32'(cmp_pin) << 14)), 80'(rdat));
    // Readback of default gain, offset and input codes
    for (int i = 0; i < 8; i++) begin
      acc(1'b1, ADDR_RDSEL, {6'h00, 2'(i), rb_tab[i][23:16], 16'h0000}, 1'b0);
      acc(1'b0, ADDR_RDBACK, 32'h0, 1'b0);
      chk("readback", 80'(rb_tab[i]), 80'(rdat));
    end
    // Refused accesses
    acc(1'b0, 12'h0FC, 32'h0, 1'b1);
    chk("unmapped read", 80'h0, 80'(rdat));
    acc(1'b1, ADDR_ALARM, 32'h0, 1'b1);
    acc(1'b1, ADDR_DACWR, dw(0, 2'h0, 6'h00, 16'h1234), 1'b1);
    // Random gain, offset and codes per channel, loaded by a mode change
    for (int ch = 0; ch < NCH; ch++) begin
      g = 16'($random(seed));
      o = 16'($random(seed));
      x = 16'($random(seed));
      xb = 16'($random(seed));
      acc(1'b1, ADDR_DACWR, dw(ch, RBT_GAIN, 6'h00, g), 1'b0);
      acc(1'b1, ADDR_DACWR, dw(ch, RBT_OFFS, 6'h00, o), 1'b0);
      acc(1'b1, ADDR_DACWR, dw(ch, RBT_X1, 6'h00, x), 1'b0);
      acc(1'b1, ADDR_DACWR, dw(ch, RBT_X1, 6'h01, xb), 1'b0);
      tick(2);
      chk("force before load", 80'h8000, 80'(dac_out_q[ch].force_lvl));
      acc(1'b1, ADDR_PMU0 + 12'(4 * ch), 32'h20_0000, 1'b0);
      tick(2);
      chk("force v slot", 80'(cal(x, g, o)), 80'(dac_out_q[ch].force_lvl));
      chk("pmu word", 80'h20_0000, 80'(pmu_q[ch]));
      chk("switch on", 80'h1, 80'(force_sw_q[ch]));
      acc(1'b1, ADDR_PMU0 + 12'(4 * ch), 32'h28_0000, 1'b0);
      tick(2);
      chk("force i slot", 80'(xb), 80'(dac_out_q[ch].force_lvl));
    end
    // High-impedance mode loads force and clamp codes at once
    // Channel 3 still holds the last random gain and offset in g and o
    acc(1'b1, ADDR_PMU0 + 12'h00C, 32'h30_0000, 1'b0);
    tick(2);
    chk("switch hiz", 80'h0, 80'(force_sw_q[3]));
    acc(1'b1, ADDR_DACWR, dw(3, RBT_X1, 6'h00, 16'h0000), 1'b0);
    acc(1'b1, ADDR_DACWR, dw(3, RBT_X1, 6'h12, 16'h9ABC), 1'b0);
    acc(1'b1, ADDR_DACWR, dw(3, RBT_X1, 6'h06, 16'h5555), 1'b0);
    acc(1'b1, ADDR_DACWR, dw(1, RBT_X1, 6'h14, 16'h0C0D), 1'b0);
    tick(2);
    chk("hiz force", 80'(cal(16'h0000, g, o)), 80'(dac_out_q[3].force_lvl));
    chk("hiz clamp", 80'h9ABC, 80'(dac_out_q[3].clamp_lo));
    chk("hiz compare", 80'h0000, 80'(dac_out_q[3].cmp_lo));
    chk("offset load", 80'h0C0D, 80'(offset_dac_q));
    // Temperature event latched, then cleared by bit 6
    @(posedge clock);
    overtemp_pin <= 1'b1;
    tick(6);
    @(posedge clock);
    overtemp_pin <= 1'b0;
    tick(6);
    acc(1'b0, ADDR_PMU0, 32'h0, 1'b0);
    chk("latched alarm", 80'h1, 80'(rdat[6:5]));
    acc(1'b1, ADDR_PMU0, 32'h30_0040, 1'b0);
    acc(1'b0, ADDR_PMU0, 32'h0, 1'b0);
    chk("alarm cleared", 80'h3, 80'(rdat[6:5]));
    report_and_stop();
  end
endmodule
`default_nettype wire
